// [input_mux_lock_config_reg.sv]
`include "input_mux_lock_config_defines.svh"
module input_mux_lock_config_reg (
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rstn_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic [3:0]  pstrb_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Storage loader
    input  wire logic        load_i,
    input  wire logic [27:0] load_data_i,
    // Pin and lock inputs
    input  wire logic [1:0]  ref_sel_pin_i,
    input  wire logic        pfd_tick_i,
    input  wire logic        digital_lock_i,
    input  wire logic        analog_lock_i,
    // Input buffer controls
    output logic [1:0]       buffer_type_o,
    output logic             buffer_type_bad_o,
    output logic             coupling_type_o,
    output logic             input_hysteresis_on_o,
    output logic             primary_term_on_o,
    output logic             primary_neg_bias_on_o,
    output logic             secondary_neg_bias_on_o,
    output logic             input_on_a_o,
    // Smart mux controls
    output logic             choose_primary_ref_o,
    output logic             choose_secondary_ref_o,
    output logic             choose_auxiliary_ref_o,
    output logic             auto_select_o,
    output logic             auto_use_aux_o,
    // PLL controls
    output logic [7:0]       input_divider_setting_o,
    output logic [3:0]       lock_window_o,
    output logic             pll_lock_o
);
    logic [27:0] cfg_ff;
    logic [27:0] nxt_cfg;
    logic [31:0] prdata_ff;
    logic        slverr_ff;
    logic [27:0] strb_mask;
    logic        hit;
    logic        access;
    logic [2:0]  sel;
    logic        stored_sel;
    logic        dig_locked;
    input_mux_lock_config_pkg::ref_mode_e ref_mode;

    assign hit    = (paddr_i == `CFG_ADDR);
    assign access = psel_i && penable_i;
    assign strb_mask = {{4{pstrb_i[3]}}, {8{pstrb_i[2]}}, {8{pstrb_i[1]}}, {8{pstrb_i[0]}}};

    // Loader has priority over a bus write in the same cycle
    always_comb begin
        nxt_cfg = cfg_ff;
        if (load_i) begin
            nxt_cfg = load_data_i & `CFG_WMASK;
        end else if (access && pwrite_i && hit) begin
            nxt_cfg = (cfg_ff & ~strb_mask) | (pwdata_i[27:0] & strb_mask & `CFG_WMASK);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            cfg_ff <= `CFG_RESET;
        end else begin
            cfg_ff <= nxt_cfg;
        end
    end

    // Zero wait-state slave; read data registered in setup phase
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            prdata_ff <= 32'h0000_0000;
            slverr_ff <= 1'b0;
        end else if (psel_i && !penable_i) begin
            prdata_ff <= (hit && !pwrite_i) ? {4'h0, cfg_ff} : 32'h0000_0000;
            slverr_ff <= !hit;
        end
    end

    assign pready_o  = 1'b1;
    assign prdata_o  = prdata_ff;
    assign pslverr_o = slverr_ff && access;

    assign buffer_type_o     = {cfg_ff[`BIT_BUF1], cfg_ff[`BIT_BUF0]};
    assign buffer_type_bad_o = (buffer_type_o ==
                                input_mux_lock_config_pkg::BUF_RESERVED);
    assign sel        = cfg_ff[`BIT_SEL_LO +: 3];
    assign stored_sel = cfg_ff[`BIT_STORED_SEL];

    // Bit 2 is the MSB of the printed triple
    always_comb begin
        ref_mode = input_mux_lock_config_pkg::REF_NONE;
        if (stored_sel) begin
            unique case ({sel[0], sel[1], sel[2]})
                `SEL_PRI:      ref_mode = input_mux_lock_config_pkg::REF_PRI;
                `SEL_SEC:      ref_mode = input_mux_lock_config_pkg::REF_SEC;
                `SEL_AUX:      ref_mode = input_mux_lock_config_pkg::REF_AUX;
                `SEL_AUTO_PS:  ref_mode = input_mux_lock_config_pkg::REF_AUTO_PS;
                `SEL_AUTO_PSA: ref_mode = input_mux_lock_config_pkg::REF_AUTO_PSA;
                default:       ref_mode = input_mux_lock_config_pkg::REF_NONE;
            endcase
        end else begin
            // Pin picks primary or secondary only
            unique case (ref_sel_pin_i)
                2'b01:   ref_mode = input_mux_lock_config_pkg::REF_SEC;
                2'b10:   ref_mode = input_mux_lock_config_pkg::REF_PRI;
                default: ref_mode = input_mux_lock_config_pkg::REF_NONE;
            endcase
        end
    end

    assign choose_primary_ref_o   = (ref_mode == input_mux_lock_config_pkg::REF_PRI);
    assign choose_secondary_ref_o = (ref_mode == input_mux_lock_config_pkg::REF_SEC);
    assign choose_auxiliary_ref_o = (ref_mode == input_mux_lock_config_pkg::REF_AUX);
    assign auto_select_o  = (ref_mode == input_mux_lock_config_pkg::REF_AUTO_PS) ||
                            (ref_mode == input_mux_lock_config_pkg::REF_AUTO_PSA);
    assign auto_use_aux_o = (ref_mode == input_mux_lock_config_pkg::REF_AUTO_PSA);

    assign coupling_type_o         = cfg_ff[`BIT_COUPLING];
    assign input_hysteresis_on_o   = cfg_ff[`BIT_HYST];
    assign primary_term_on_o       = !cfg_ff[`BIT_PRI_TERM];
    assign primary_neg_bias_on_o   = !cfg_ff[`BIT_PRI_BIAS];
    assign secondary_neg_bias_on_o = !cfg_ff[`BIT_SEC_BIAS];
    assign input_on_a_o = cfg_ff[`BIT_INPUT_ON_A] && cfg_ff[`BIT_COUPLING] &&
                          (buffer_type_o == input_mux_lock_config_pkg::BUF_LVDS);
    assign input_divider_setting_o = cfg_ff[`BIT_DIV_HI:`BIT_DIV_LO];
    assign lock_window_o           = cfg_ff[`BIT_LOCK_WINDOW_HI:`BIT_LOCK_WINDOW_LO];

    lock_qualifier i_lock_qualifier (
        .ref_clk_i    (ref_clk_i),
        .rstn_i       (rstn_i),
        .count_mode_i (cfg_ff[`BIT_LOCK_COUNT]),
        .pfd_tick_i   (pfd_tick_i),
        .detect_i     (digital_lock_i),
        .locked_o     (dig_locked)
    );

    assign pll_lock_o = cfg_ff[`BIT_LOCK_SRC] ? analog_lock_i : dig_locked;
endmodule : input_mux_lock_config_reg

// [input_mux_lock_config_defines.svh]
`ifndef INPUT_MUX_LOCK_CONFIG_DEFINES_SVH
`define INPUT_MUX_LOCK_CONFIG_DEFINES_SVH
// Function
// - Bits 1:0 choose the input buffer type, 00 CMOS, 10 LVPECL, 11 LVDS, 01 reserved.
// - With stored selection on, bits 4:2 pick primary, secondary, auxiliary or auto priority.
// - Stored-select bit at one: the mux follows the stored bits and ignores the select pin.
// - Stored-select bit at zero: the select pin drives the mux, no auto and no auxiliary.
// - Bit 6 selects DC coupling at one and AC coupling at zero.
// - Bit 7 at one enables input hysteresis, which software should keep on.
// - Bit 8 at zero enables primary internal termination and at one disables it.
// - Bits 9 and 10 at zero bias the primary and secondary negative pins internally.
// - Bit 11 at one enables fail-safe on every LVDS buffer with DC coupling.
// - Lock-count bit zero locks on first detection, one after 64 consecutive detector cycles.
// - Bit 27 selects digital lock indication at zero and analog at one.
`define CFG_INDEX         12'h005
// Word register: byte address is four times the index
`define CFG_ADDR          (`CFG_INDEX << 2)
`define CFG_WIDTH         28
`define CFG_RESET         28'h000_0080
`define CFG_WMASK         28'hFFF_CFFF
`define BIT_BUF0          0
`define BIT_BUF1          1
`define BIT_SEL_LO        2
`define BIT_SEL_HI        4
`define BIT_STORED_SEL    5
`define BIT_COUPLING      6
`define BIT_HYST          7
`define BIT_PRI_TERM      8
`define BIT_PRI_BIAS      9
`define BIT_SEC_BIAS      10
`define BIT_INPUT_ON_A      11
`define BIT_DIV_LO        14
`define BIT_DIV_HI        21
`define BIT_LOCK_WINDOW_LO      22
`define BIT_LOCK_WINDOW_HI      25
`define BIT_LOCK_COUNT    26
`define BIT_LOCK_SRC      27
`define SEL_PRI           3'b100
`define SEL_SEC           3'b010
`define SEL_AUX           3'b001
`define SEL_AUTO_PS       3'b110
`define SEL_AUTO_PSA      3'b111
`define LOCK_CYCLES       7'h40
`endif

// [input_mux_lock_config_pkg.sv]
package input_mux_lock_config_pkg;
    typedef enum logic [1:0] {
        BUF_CMOS,
        BUF_RESERVED,
        BUF_LVPECL,
        BUF_LVDS
    } buf_type_e;
    typedef enum logic [2:0] {
        REF_NONE,
        REF_PRI,
        REF_SEC,
        REF_AUX,
        REF_AUTO_PS,
        REF_AUTO_PSA
    } ref_mode_e;
endpackage : input_mux_lock_config_pkg

// [lock_qualifier.sv]
`include "input_mux_lock_config_defines.svh"
module lock_qualifier (
    // Clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       rstn_i,
    // Control
    input  wire logic       count_mode_i,
    input  wire logic       pfd_tick_i,
    input  wire logic       detect_i,
    // Result
    output logic            locked_o
);
    logic [6:0] cnt_ff;
    logic       locked_ff;

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            cnt_ff    <= 7'h00;
            locked_ff <= 1'b0;
        end else if (!detect_i) begin
            cnt_ff    <= 7'h00;
            locked_ff <= 1'b0;
        end else if (pfd_tick_i) begin
            if (!count_mode_i) begin
                locked_ff <= 1'b1;
            end else if (cnt_ff == `LOCK_CYCLES - 7'h01) begin
                locked_ff <= 1'b1;
            end else begin
                cnt_ff <= cnt_ff + 7'h01;
            end
        end
    end

    assign locked_o = locked_ff;
endmodule : lock_qualifier

// [input_mux_lock_config_props.sv]
module input_mux_lock_config_props (
    input wire logic        ref_clk_i, rstn_i, psel_i, penable_i, pwrite_i, load_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0]  pstrb_i,
    input wire logic [1:0]  buffer_type_o,
    input wire logic        buffer_type_bad_o, primary_term_on_o, input_on_a_o,
    input wire logic        choose_primary_ref_o, choose_auxiliary_ref_o,
    input wire logic        auto_select_o, auto_use_aux_o,
    input wire logic [7:0]  input_divider_setting_o,
    input wire logic [3:0]  lock_window_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);
    // Full-word writes only, and none with a load pulse, since the loader beats the bus
    logic        wr_ff;
    logic [31:0] wd_ff;
    always_ff @(posedge ref_clk_i) begin
        wr_ff <= rstn_i && psel_i && penable_i && pwrite_i && paddr_i == 12'h014
                 && pstrb_i == 4'hf && !load_i;
        wd_ff <= pwdata_i;
    end
    buf_type_a: assert property (wr_ff |-> buffer_type_bad_o == (wd_ff[1:0] == 2'b01)
        && buffer_type_o == wd_ff[1:0]) else $error("buffer type");
    auto_aux_a: assert property (wr_ff && wd_ff[5]
        |-> auto_use_aux_o == (wd_ff[4:2] == 3'b111)) else $error("auto aux");
    stored_mux_a: assert property (wr_ff && wd_ff[5:2] == 4'b1001
        |-> choose_primary_ref_o) else $error("stored mux");
    pin_mode_a: assert property (wr_ff && !wd_ff[5]
        |-> !auto_select_o && !choose_auxiliary_ref_o) else $error("pin mode");
    prim_term_a: assert property (wr_ff |-> primary_term_on_o != wd_ff[8])
        else $error("termination");
    fail_safe_a: assert property (wr_ff
        |-> input_on_a_o == (wd_ff[11] && wd_ff[6] && wd_ff[1:0] == 2'b11))
        else $error("input_on_a");
    divider_a: assert property (wr_ff |-> input_divider_setting_o == wd_ff[21:14])
        else $error("divider");
    lock_win_a: assert property (wr_ff |-> lock_window_o == wd_ff[25:22])
        else $error("lock window");
    cover property (wr_ff && wd_ff[5]);
    cover property (wr_ff && !wd_ff[5]);
    cover property (wr_ff && input_on_a_o);
endmodule : input_mux_lock_config_props

bind input_mux_lock_config_reg input_mux_lock_config_props i_props (.*);

// [input_mux_lock_config_reg_bench.sv]
module input_mux_lock_config_reg_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk_i = 0, rstn_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, load_i = 0;
    logic pfd_tick_i = 0, digital_lock_i = 0, analog_lock_i = 0, pready_o, pslverr_o;
    logic [11:0] paddr_i = '0;
    logic [31:0] pwdata_i = '0, prdata_o, d, exp_q[$];
    logic [3:0] pstrb_i = 4'hf, lock_window_o;
    logic [27:0] load_data_i = '0;
    logic [1:0] ref_sel_pin_i = '0, buffer_type_o;
    logic buffer_type_bad_o, coupling_type_o, input_hysteresis_on_o, primary_term_on_o;
    logic primary_neg_bias_on_o, secondary_neg_bias_on_o, input_on_a_o, pll_lock_o;
    logic choose_primary_ref_o, choose_secondary_ref_o, choose_auxiliary_ref_o;
    logic auto_select_o, auto_use_aux_o;
    logic [7:0] input_divider_setting_o;
    int n_errors = 0, comparisons = 0, cyc = 0;
    input_mux_lock_config_reg i_input_mux_lock_config_reg (.*);
    always #50 ref_clk_i = ~ref_clk_i;
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic conclude();
        $display("mismatches %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : conclude
    task automatic apb(logic w, logic [11:0] a, logic [31:0] v);
        @(posedge ref_clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= v;
        @(posedge ref_clk_i);
        penable_i <= 1'b1;
        do @(posedge ref_clk_i); while (pready_o !== 1'b1);
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb
    task automatic wr(logic [31:0] v);
        apb(1'b1, 12'h014, v);
        @(negedge ref_clk_i);
    endtask : wr
    // Extra edge leaves room for a registered lock flag
    task automatic tick(int n);
        repeat (n) begin
            @(posedge ref_clk_i);
            pfd_tick_i <= 1'b1;
            @(posedge ref_clk_i);
            pfd_tick_i <= 1'b0;
        end
        @(posedge ref_clk_i);
        @(negedge ref_clk_i);
    endtask : tick
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_errors++;
            conclude();
        end
        if (psel_i && penable_i && pready_o) begin
            chk("pslverr", paddr_i != 12'h014, pslverr_o);
            if (!pwrite_i) chk("prdata", exp_q.pop_front(), prdata_o);
        end
    end
    initial begin
        logic [2:0] t [5] = '{3'b100, 3'b010, 3'b001, 3'b110, 3'b111};
        void'($urandom(43490));
        repeat (2) @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        @(negedge ref_clk_i);
        chk("hysteresis", 1, input_hysteresis_on_o);
        for (int i = 0; i < 4; i++) begin
            wr(32'h0000_0080 | i);
            chk("buftype", {i[1:0], i == 1}, {buffer_type_o, buffer_type_bad_o});
        end
        foreach (t[j]) begin
            @(posedge ref_clk_i);
            ref_sel_pin_i <= 2'($urandom);
            wr({24'h0, 3'b101, t[j][0], t[j][1], t[j][2], 2'b00});
            chk("auto", {&t[j][2:1], t[j] == 3'b111}, {auto_select_o, auto_use_aux_o});
            if (!(&t[j][2:1])) chk("mux", t[j], {choose_primary_ref_o,
                choose_secondary_ref_o, choose_auxiliary_ref_o});
        end
        wr(32'h0000_009c);
        for (int p = 1; p < 3; p++) begin
            @(posedge ref_clk_i);
            ref_sel_pin_i <= p[1:0];
            @(negedge ref_clk_i);
            chk("pin", {p[1:0], 2'b00}, {choose_primary_ref_o,
                choose_secondary_ref_o, choose_auxiliary_ref_o, auto_select_o});
        end
        for (int k = 0; k < 4; k++) begin
            d = $urandom | 32'h0000_0080 | (k == 0 ? 32'h0000_0843 : 32'h0);
            wr(d);
            chk("window", d[25:22], lock_window_o);
            chk("divider", d[21:14], input_divider_setting_o);
            chk("coupling", d[6], coupling_type_o);
            chk("term", {~d[8]}, primary_term_on_o);
            chk("bias", {~d[10:9]}, {secondary_neg_bias_on_o, primary_neg_bias_on_o});
            chk("input_on_a", d[11] & d[6] & (&d[1:0]), input_on_a_o);
            exp_q.push_back(d & 32'h0fff_cfff);
            apb(1'b0, 12'h014, '0);
        end
        // One byte lane only; the other lanes must keep their contents
        @(posedge ref_clk_i);
        pstrb_i <= 4'b0010;
        wr(32'h0000_ff00);
        exp_q.push_back((d & 32'h0fff_00ff) | 32'h0000_cf00);
        apb(1'b0, 12'h014, '0);
        pstrb_i <= 4'hf;
        exp_q.push_back('0);
        apb(1'b1, 12'h018, '1);
        apb(1'b0, 12'h018, '0);
        @(posedge ref_clk_i);
        load_i <= 1'b1;
        load_data_i <= 28'($urandom) | 28'h000_0080;
        @(posedge ref_clk_i);
        load_i <= 1'b0;
        @(negedge ref_clk_i);
        chk("load", load_data_i[21:14], input_divider_setting_o);
        wr(32'h0000_0080);
        @(posedge ref_clk_i);
        digital_lock_i <= 1'b1;
        tick(1);
        chk("lock first", 1, pll_lock_o);
        wr(32'h0400_0080);
        @(posedge ref_clk_i);
        digital_lock_i <= 1'b0;
        tick(1);
        @(posedge ref_clk_i);
        digital_lock_i <= 1'b1;
        tick(63);
        chk("lock 63", 0, pll_lock_o);
        tick(1);
        chk("lock 64", 1, pll_lock_o);
        wr(32'h0800_0080);
        for (int a = 1; a >= 0; a--) begin
            @(posedge ref_clk_i);
            analog_lock_i <= a[0];
            @(negedge ref_clk_i);
            chk("analog", a, pll_lock_o);
        end
        conclude();
    end
endmodule : input_mux_lock_config_reg_bench
